// file: verilog/cio_cfg.svh
`ifndef CIO_CFG_SVH
`define CIO_CFG_SVH

// register byte offsets
`define CIO_CTRL_OFS        12'h000
`define CIO_IOCFG_OFS       12'h004
`define CIO_STAT_OFS        12'h008

// control register fields
`define CIO_CTRL_CONFIG_BIT 0
`define CIO_CTRL_LINV_LO    1
`define CIO_CTRL_LINV_HI    2
`define CIO_CTRL_WIDTH      3
`define CIO_CTRL_RST        3'h0

// cell configuration register fields
`define CIO_CFG_IN_LATCH    0
`define CIO_CFG_IN_INV      1
`define CIO_CFG_IN_SEL      2
`define CIO_CFG_OUT_SEL     3
`define CIO_CFG_OUT_REG     4
`define CIO_CFG_OUT_INV     5
`define CIO_CFG_TS_LO       6
`define CIO_CFG_TS_HI       7
`define CIO_CFG_TS_INV      8
`define CIO_CFG_SLEW        9
`define CIO_CFG_PULLUP      10
`define CIO_CFG_WIDTH       11
`define CIO_CFG_RST         11'h040

// status register fields
`define CIO_STAT_PAD        0
`define CIO_STAT_INQ        1
`define CIO_STAT_OUTQ       2
`define CIO_STAT_PADOUT     3
`define CIO_STAT_PADOE      4
`define CIO_STAT_CONFIG     5
`define CIO_STAT_CHIPRST    6

`endif

// file: verilog/cio_pkg.sv
`default_nettype none

package cio_pkg;

	// output buffer three-state mode
	typedef enum logic [1:0] {
		CIO_TS_ON  = 2'h0,
		CIO_TS_OFF = 2'h1,
		CIO_TS_NET = 2'h2,
		CIO_TS_RSV = 2'h3
	} cio_ts_mode_e;

	typedef logic [31:0] cio_word_t;

endpackage

`default_nettype wire

// file: verilog/cio_edge_clk.sv
`timescale 1ns/1ps
`default_nettype none

module cio_edge_clk #(
	parameter int LINES = 2
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// edge clock lines
	input  wire logic [LINES-1:0] line_raw,
	input  wire logic [LINES-1:0] line_inv,
	// buffered lines
	output logic      [LINES-1:0] line_lvl,
	output logic      [LINES-1:0] line_rise
);

	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			logic next_lvl;
			logic next_rise;

			always_comb begin
				next_lvl  = line_raw[g] ^ line_inv[g];
				next_rise = next_lvl & ~line_lvl[g];
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					line_lvl[g]  <= 1'b0;
					line_rise[g] <= 1'b0;
				end else begin
					line_lvl[g]  <= next_lvl;
					line_rise[g] <= next_rise;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// file: verilog/cio_in_store.sv
`timescale 1ns/1ps
`default_nettype none

module cio_in_store (
	// clock and clear
	input  wire logic pclk,
	input  wire logic clr_n,
	// configuration
	input  wire logic latch_mode,
	// load and data
	input  wire logic load,
	input  wire logic d,
	// stored value
	output logic      q
);

	logic load_q;
	logic next_load_q;
	logic next_q;

	always_comb begin
		next_load_q = load;
		next_q      = q;
		if (latch_mode) begin
			if (!load)
				next_q = d;
		end else if (load && !load_q) begin
			next_q = d;
		end
	end

	// clear dominates any load while held
	always_ff @(posedge pclk or negedge clr_n) begin
		if (!clr_n) begin
			q      <= 1'b0;
			load_q <= 1'b1;
		end else begin
			q      <= next_q;
			load_q <= next_load_q;
		end
	end

endmodule

`default_nettype wire

// file: verilog/cio_cell.sv
// Summary of operation
// - input element is a rising-edge flip-flop or a latch open while load is low.
// - input element clock sense invertible per cell by its own configuration bit.
// - input load and output clock each pick one of two edge lines.
// - input and output storage elements cleared while configuring and while chip reset is low.
// - direct pad input and registered input are both offered at once.
// - output data comes from the data net directly or through a rising-edge flop.
// - each edge clock line passes a buffer with configurable inversion.
// - one bit inverts the output data before the buffer.
// - buffer is always on, always off, or steered by the control net.
// - under net control, 1 floats the pin and 0 drives it.
// - one bit inverts the control net into an active-high enable.
// - output offers full-speed or slew-limited transitions.
// - a selectable weak pull-up holds an undriven pin high.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cio_cfg.svh"

module cio_cell #(
	parameter int ADDR_W = 12,
	parameter int LINES  = 2
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// chip level
	input  wire logic              chip_reset_n,
	input  wire logic [LINES-1:0]  edge_clk_line,
	// pad side
	input  wire logic              pad_in,
	output logic                   pad_out,
	output logic                   pad_oe,
	output logic                   slew_limit,
	output logic                   pullup_en,
	// user logic side
	input  wire logic              output_data,
	input  wire logic              ts_ctrl,
	output logic                   direct_in,
	output logic                   registered_in
);

	// configuration state
	logic [`CIO_CTRL_WIDTH-1:0] ctrl;
	logic [`CIO_CFG_WIDTH-1:0]  iocfg;
	logic [`CIO_CTRL_WIDTH-1:0] next_ctrl;
	logic [`CIO_CFG_WIDTH-1:0]  next_iocfg;

	// bus answer state
	logic [31:0]                next_prdata;
	logic                       next_pready;
	logic                       next_pslverr;
	logic                       wr_take;
	logic [31:0]                rd_word;
	logic [31:0]                stat_word;

	// pad side state
	logic                       out_q;
	logic                       next_out_q;
	logic                       next_pad_out;
	logic                       next_pad_oe;
	logic                       next_slew_limit;
	logic                       next_pullup_en;
	logic                       next_direct_in;
	logic                       oe_sel;

	// decoded fields
	logic                       configuring;
	logic [LINES-1:0]           line_inv;
	logic                       in_latch;
	logic                       in_inv;
	logic                       in_sel;
	logic                       out_sel;
	logic                       out_reg;
	logic                       out_inv;
	cio_pkg::cio_ts_mode_e      ts_mode;
	logic                       ts_inv;

	// buffered clock lines
	logic [LINES-1:0]           line_lvl;
	logic [LINES-1:0]           line_rise;

	logic                       store_clr_n;
	logic                       in_load;
	logic                       out_src;
	logic                       access;
	logic                       hit_ctrl;
	logic                       hit_cfg;
	logic                       hit_stat;

	assign configuring = ctrl[`CIO_CTRL_CONFIG_BIT];
	assign line_inv    = ctrl[`CIO_CTRL_LINV_HI:`CIO_CTRL_LINV_LO];
	assign in_latch    = iocfg[`CIO_CFG_IN_LATCH];
	assign in_inv      = iocfg[`CIO_CFG_IN_INV];
	assign in_sel      = iocfg[`CIO_CFG_IN_SEL];
	assign out_sel     = iocfg[`CIO_CFG_OUT_SEL];
	assign out_reg     = iocfg[`CIO_CFG_OUT_REG];
	assign out_inv     = iocfg[`CIO_CFG_OUT_INV];
	assign ts_mode     = cio_pkg::cio_ts_mode_e'(iocfg[`CIO_CFG_TS_HI:`CIO_CFG_TS_LO]);
	assign ts_inv      = iocfg[`CIO_CFG_TS_INV];

	// configuring comes from a flop, so the combined clear is glitch-free on that leg
	assign store_clr_n = presetn & chip_reset_n & ~configuring;

	// only two lines exist per edge, so one select bit picks the line
	assign in_load = line_lvl[in_sel] ^ in_inv;
	assign out_src = out_reg ? out_q : output_data;

	// apb decode
	assign access   = psel & penable & ~pready;
	assign hit_ctrl = (paddr == ADDR_W'(`CIO_CTRL_OFS));
	assign hit_cfg  = (paddr == ADDR_W'(`CIO_IOCFG_OFS));
	assign hit_stat = (paddr == ADDR_W'(`CIO_STAT_OFS));

	cio_edge_clk #(
		.LINES     (LINES)
	) u_edge_clk (
		.pclk      (pclk),
		.presetn   (presetn),
		.line_raw  (edge_clk_line),
		.line_inv  (line_inv),
		.line_lvl  (line_lvl),
		.line_rise (line_rise)
	);

	// input element samples the raw pad, which makes it a usable synchroniser
	cio_in_store u_in_store (
		.pclk       (pclk),
		.clr_n      (store_clr_n),
		.latch_mode (in_latch),
		.load       (in_load),
		.d          (pad_in),
		.q          (registered_in)
	);

	// a write lands only at the edge where the master sees pready high
	assign wr_take = psel & penable & pready & pwrite;

	// configuration registers, byte lanes gated by pstrb
	always_comb begin
		next_ctrl  = ctrl;
		next_iocfg = iocfg;
		if (wr_take && hit_ctrl && pstrb[0])
			next_ctrl = pwdata[`CIO_CTRL_WIDTH-1:0];
		if (wr_take && hit_cfg && pstrb[0])
			next_iocfg[7:0] = pwdata[7:0];
		if (wr_take && hit_cfg && pstrb[1])
			next_iocfg[`CIO_CFG_WIDTH-1:8] = pwdata[`CIO_CFG_WIDTH-1:8];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl  <= `CIO_CTRL_RST;
			iocfg <= `CIO_CFG_RST;
		end else begin
			ctrl  <= next_ctrl;
			iocfg <= next_iocfg;
		end
	end

	// status snapshot, read-only
	always_comb begin
		stat_word                      = 32'h0000_0000;
		stat_word[`CIO_STAT_PAD]       = direct_in;
		stat_word[`CIO_STAT_INQ]       = registered_in;
		stat_word[`CIO_STAT_OUTQ]      = out_q;
		stat_word[`CIO_STAT_PADOUT]    = pad_out;
		stat_word[`CIO_STAT_PADOE]     = pad_oe;
		stat_word[`CIO_STAT_CONFIG]    = configuring;
		stat_word[`CIO_STAT_CHIPRST]   = ~chip_reset_n;
	end

	// read word, zero for unmapped offsets
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_ctrl)
			rd_word[`CIO_CTRL_WIDTH-1:0] = ctrl;
		if (hit_cfg)
			rd_word[`CIO_CFG_WIDTH-1:0] = iocfg;
		if (hit_stat)
			rd_word = stat_word;
	end

	// one wait state: the answer stands for a single cycle
	always_comb begin
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0000_0000;
		if (access) begin
			next_pready  = 1'b1;
			next_pslverr = ~(hit_ctrl | hit_cfg | hit_stat);
			if (!pwrite)
				next_prdata = rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// output flop on the selected line's rising edge
	always_comb begin
		next_out_q = out_q;
		if (line_rise[out_sel])
			next_out_q = output_data;
	end

	always_ff @(posedge pclk or negedge store_clr_n) begin
		if (!store_clr_n)
			out_q <= 1'b0;
		else
			out_q <= next_out_q;
	end

	// buffer enable: on, off, or steered by the control net
	always_comb begin
		case (ts_mode)
			cio_pkg::CIO_TS_ON: begin
				oe_sel = 1'b1;
			end
			cio_pkg::CIO_TS_OFF: begin
				oe_sel = 1'b0;
			end
			cio_pkg::CIO_TS_NET: begin
				// same net on data and control gives a low-only driver
				oe_sel = ts_inv ? ts_ctrl : ~ts_ctrl;
			end
			cio_pkg::CIO_TS_RSV: begin
				// spare code parks the buffer rather than guessing a meaning
				oe_sel = 1'b0;
			end
			default: begin
				oe_sel = 1'b0;
			end
		endcase
	end

	// pad drive and enable
	always_comb begin
		next_pad_out = out_src ^ out_inv;
		// keep the pin quiet while the cell is being configured
		next_pad_oe  = oe_sel & ~configuring;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_out <= 1'b0;
			pad_oe  <= 1'b0;
		end else begin
			pad_out <= next_pad_out;
			pad_oe  <= next_pad_oe;
		end
	end

	// pin options follow the configuration word
	always_comb begin
		next_slew_limit = iocfg[`CIO_CFG_SLEW];
		next_pullup_en  = iocfg[`CIO_CFG_PULLUP];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slew_limit <= 1'b0;
			pullup_en  <= 1'b0;
		end else begin
			slew_limit <= next_slew_limit;
			pullup_en  <= next_pullup_en;
		end
	end

	// direct input copy, one cycle behind the pin
	always_comb begin
		next_direct_in = pad_in;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			direct_in <= 1'b0;
		else
			direct_in <= next_direct_in;
	end

endmodule

`default_nettype wire

// file: sim/cio_pad_model.sv
`timescale 1ns/1ps
`default_nettype none

module cio_pad_model (
	// clock
	input  wire logic pclk,
	// cell side
	input  wire logic pad_out,
	input  wire logic pad_oe,
	input  wire logic pullup_en,
	// outside driver
	input  wire logic ext_drv,
	input  wire logic ext_val,
	// pin level
	output logic      pad_in
);
	// an undriven pin wanders, so a missing pull-up cannot pass by luck
	logic flt = 1'b0;
	always @(posedge pclk) flt <= !flt;
	assign pad_in = pad_oe ? pad_out : ext_drv ? ext_val : pullup_en ? 1'b1 : flt;
endmodule

`default_nettype wire

// file: sim/cio_cell_properties.sv
`timescale 1ns/1ps
`default_nettype none

module cio_cell_chk #(
	parameter int ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// cell
	input wire logic              chip_reset_n,
	input wire logic              pad_in,
	input wire logic              pad_out,
	input wire logic              pad_oe,
	input wire logic              output_data,
	input wire logic              ts_ctrl,
	input wire logic              direct_in,
	input wire logic              registered_in
);
	logic [10:0] cfg;
	logic [10:0] next_cfg;
	logic        cf;
	logic        next_cf;
	logic        wr;
	logic        oe_want;
	logic        dx;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of the configuration, tracked from completed writes
	always_comb begin
		wr = psel && penable && pready && pwrite;
		next_cfg = cfg;
		next_cf = cf;
		if (wr && paddr == 12'h004 && pstrb[0]) next_cfg[7:0] = pwdata[7:0];
		if (wr && paddr == 12'h004 && pstrb[1]) next_cfg[10:8] = pwdata[10:8];
		if (wr && paddr == 12'h000 && pstrb[0]) next_cf = pwdata[0];
		oe_want = !cf && (cfg[7:6] == 2'h0 || (cfg[7:6] == 2'h2 && ts_ctrl == cfg[8]));
		dx = output_data ^ cfg[5];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= 11'h040;
			cf <= 1'b0;
		end else begin
			cfg <= next_cfg;
			cf <= next_cf;
		end
	end
	property p_ready_one; pready |=> !pready; endproperty
	a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
	property p_ready_wait; psel && penable && !pready |=> pready; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready late");
	property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_direct; $past(presetn) |-> direct_in == $past(pad_in); endproperty
	a_direct: assert property (p_direct) else $error("direct input wrong");
	property p_chip_clr; !chip_reset_n |-> !registered_in; endproperty
	a_chip_clr: assert property (p_chip_clr) else $error("chip reset not clearing");
	property p_cfg_clr; cf && $past(cf) |-> !registered_in; endproperty
	a_cfg_clr: assert property (p_cfg_clr) else $error("configuring not clearing");
	property p_oe; $past(presetn) && $stable({cf, cfg}) |-> pad_oe == $past(oe_want); endproperty
	a_oe: assert property (p_oe) else $error("output enable wrong");
	property p_dout; $past(presetn) && $stable(cfg) && !cfg[4] |-> pad_out == $past(dx); endproperty
	a_dout: assert property (p_dout) else $error("direct output wrong");
	c_net: cover property (cfg[7:6] == 2'h2 && pad_oe);
	c_regout: cover property (cfg[4] && pad_out);
	c_err: cover property (pready && pslverr);
endmodule

bind cio_cell cio_cell_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .chip_reset_n, .pad_in, .pad_out, .pad_oe,
	.output_data, .ts_ctrl, .direct_in, .registered_in);

`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, crst_n;
	logic               pad_in, pad_out, pad_oe, slew_limit, pullup_en, od, ts, e_oe;
	logic               direct_in, registered_in, ext_drv, ev;
	logic [11:0]        paddr;
	logic [3:0]         pstrb;
	logic [1:0]         ecl;
	cio_pkg::cio_word_t pwdata, prdata, rdat;
	int                 fail_count, checks_done, k, s, v;

	cio_cell DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .chip_reset_n(crst_n), .edge_clk_line(ecl), .pad_in, .pad_out, .pad_oe, .slew_limit,
		.pullup_en, .output_data(od), .ts_ctrl(ts), .direct_in, .registered_in);
	cio_pad_model u_pad (.pclk, .pad_out, .pad_oe, .pullup_en, .ext_drv, .ext_val(ev), .pad_in);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic apb(input logic w, input logic [11:0] a, input cio_pkg::cio_word_t d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// the rising edge that sees pready high takes the answer and ends the request
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			$display("[FAIL] pready expected 1 seen %b", pready);
			fail_count++;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge pclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge pclk);
		$display("[FAIL] timeout expected finish seen hang");
		fail_count++;
		results();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, crst_n, ecl, od, ts, ext_drv, ev} = '0;
		pstrb = 4'hf;
		fail_count = 0;
		checks_done = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		crst_n <= 1'b1;
		apb(0, 12'h000, 0);
		chk("ctrl", 0, rdat);
		apb(0, 12'h004, 0);
		chk("iocfg", 32'h040, rdat);
		chk("oe_rst", 0, pad_oe);
		apb(1, 12'h008, '1);
		chk("stat_wr", 0, rerr);
		apb(0, 12'h00c, 0);
		chk("bad_err", 1, rerr);
		chk("bad_data", 0, rdat);
		apb(1, 12'h004, 32'h7ff);
		apb(0, 12'h004, 0);
		chk("iocfg_rw", 32'h7ff, rdat);
		chk("slew", 1, slew_limit);
		chk("pullup", 1, pullup_en);
		chk("pull_pin", 1, direct_in);
		for (k = 0; k < 32; k++) begin
			apb(1, 12'h004, {k[2], k[1:0], k[4], 5'h00});
			@(posedge pclk);
			ts <= k[3];
			od <= k[3] ^ k[0];
			wt(3);
			e_oe = k[1:0] == 2'h0 || (k[1:0] == 2'h2 && k[3] == k[2]);
			chk("oe", e_oe, pad_oe);
			chk("dout", k[3] ^ k[0] ^ k[4], pad_out);
			if (e_oe) chk("din", k[3] ^ k[0] ^ k[4], direct_in);
		end
		for (s = 0; s < 2; s++)
			for (v = 0; v < 2; v++) begin
				apb(1, 12'h000, v << (s + 1));
				apb(1, 12'h004, 32'h010 | s << 3);
				@(posedge pclk);
				ecl <= {v[0], v[0]};
				crst_n <= 1'b0;
				od <= 1'b1;
				wt(3);
				@(posedge pclk);
				ecl[s] <= !v[0];
				wt(4);
				chk("clr", 0, pad_out);
				@(posedge pclk);
				ecl <= {v[0], v[0]};
				crst_n <= 1'b1;
				wt(3);
				@(posedge pclk);
				ecl[1 - s] <= !v[0];
				wt(4);
				chk("other", 0, pad_out);
				@(posedge pclk);
				ecl[s] <= !v[0];
				wt(4);
				chk("rise", 1, pad_out);
				@(posedge pclk);
				ecl <= {v[0], v[0]};
				od <= 1'b0;
				wt(4);
				chk("hold", 1, pad_out);
			end
		apb(1, 12'h000, 0);
		for (k = 0; k < 8; k++) begin
			apb(1, 12'h004, 32'h040 | k);
			@(posedge pclk);
			ecl <= {k[1], k[1]};
			ext_drv <= 1'b1;
			ev <= 1'b1;
			crst_n <= 1'b0;
			wt(3);
			@(posedge pclk);
			crst_n <= 1'b1;
			wt(4);
			chk("in_low", k[0], registered_in);
			@(posedge pclk);
			ecl[k[2]] <= !k[1];
			wt(4);
			@(posedge pclk);
			ev <= 1'b0;
			wt(4);
			chk("in_hold", 1, registered_in);
		end
		apb(1, 12'h004, 0);
		wt(2);
		chk("oe_on", 1, pad_oe);
		apb(1, 12'h000, 1);
		wt(2);
		chk("cfg_clr", 0, registered_in);
		chk("cfg_oe", 0, pad_oe);
		apb(0, 12'h008, 0);
		chk("stat_cfg", 1, rdat[5]);
		results();
	end
endmodule

`default_nettype wire
